// >>> rtl/lsim_map.svh
// Constants of the line status indication mux.
// Assumes APB byte addresses and the 10 MHz channel clock.
`ifndef LSIM_MAP_SVH
`define LSIM_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LSIM_RX_CFG_OFS 8'h00
`define LSIM_TX_CFG_OFS 8'h04
`define LSIM_STAT_OFS 8'h08

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LSIM_SEL_MSB 7
`define LSIM_SEL_LSB 5
`define LSIM_FMT_MSB 1
`define LSIM_FMT_LSB 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LSIM_RX_CFG_RST 8'h00
`define LSIM_TX_CFG_RST 8'h00

// ----------------------------------------
// Pattern detector counts
// ----------------------------------------
`define LSIM_SYNC_RUN 7'h40
`define LSIM_ERR_LIMIT 7'h06

`endif

// >>> rtl/lsim_pkg.sv
// Types of the line status indication mux.
// Assumes lsim_map.svh supplies every number.
package lsim_pkg;

  // ----------------------------------------
  // Receive system format
  // ----------------------------------------
  typedef enum logic [1:0] {
    LSIM_RXF_SR_NRZ = 2'b00,
    LSIM_RXF_DR_NRZ = 2'b01,
    LSIM_RXF_DR_SLICED = 2'b10
  } lsim_rx_fmt_t;

  // ----------------------------------------
  // Transmit system format
  // ----------------------------------------
  typedef enum logic [1:0] {
    LSIM_TXF_SR_NRZ = 2'b00,
    LSIM_TXF_DR_NRZ = 2'b01,
    LSIM_TXF_DR_RZ = 2'b10
  } lsim_tx_fmt_t;

  // ----------------------------------------
  // Detector status carriers
  // ----------------------------------------
  typedef struct packed {
    logic pat_valid;
    logic pat_match;
    logic alarm;
    logic loss;
    logic exz;
    logic viol;
    logic pos;
    logic neg;
  } lsim_rx_stat_t;

  typedef struct packed {
    logic pat_valid;
    logic pat_match;
    logic alarm;
    logic over_cur;
    logic line_loss;
    logic exz;
    logic viol;
    logic loss;
  } lsim_tx_stat_t;

endpackage

// >>> rtl/lsim_top.sv
// Per-channel receive and transmit indication mux with APB registers.
// Assumes detectors run on i_clk and give one-cycle event strobes;
// the recovered clock and the shared transmit pin arrive from outside.
//
// Functional notes
// - Rx select 000: pin high while rx pattern synchronized, else low.
// - Rx select 000 in sync: pin low one cycle per pattern error.
// - Rx select 001: pin mirrors line alarm status.
// - Rx select 010: pin shows XOR of sliced positive and negative rails.
// - Rx select 011: pin carries the recovered receive clock.
// - Rx select 100: one-cycle high pulse per line excess zeroes event.
// - Rx select 101: one-cycle high pulse per line violation.
// - Rx select 110: one-cycle pulse on excess zeroes or violation.
// - Rx select 111: pin mirrors line signal loss status.
// - Tx negative data pin turns output in single-rail NRZ, dual RZ.
// - Tx select field is bits 7 to 5 of tx config.
// - Tx select 000: sync level, low one cycle per pattern error.
// - Tx select 001: pin mirrors system alarm status.
// - Tx select 010: pin mirrors over-current status.
// - Tx select 011: pin mirrors tx line signal loss.
// - Tx select 100: one-cycle pulse per system excess zeroes.
// - Tx select 101: one-cycle pulse per system violation.
// - Tx select 110: one-cycle pulse on system zeroes or violation.
// - Tx select 111: pin mirrors system signal loss status.
// - Tx single-rail NRZ: selects 101, 110, 111 give a low pin.
// - Rx indication on negative data pin or on recovered clock pin.
// - Rx select field is bits 7 to 5 of rx config.
// - Sync after over 64 matches; lose on over 6 errors in 64 bits.
`timescale 1ns/1ps
`include "lsim_map.svh"

module lsim_top
  import lsim_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // Detector status
  input wire lsim_rx_stat_t i_rx_stat,
  input wire lsim_tx_stat_t i_tx_stat,
  // Pins
  input wire logic i_recovered_clock,
  input wire logic i_tx_negative_data_pin,
  output logic o_tx_negative_data_pin,
  output logic o_tx_negative_data_oe,
  output logic o_rx_negative_data_pin,
  output logic o_recovered_clock_pin
);

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [7:0] rx_config_reg_q;
  logic [7:0] tx_config_reg_q;

  wire [2:0] rx_sel =
    rx_config_reg_q[`LSIM_SEL_MSB:`LSIM_SEL_LSB];
  wire [2:0] tx_sel =
    tx_config_reg_q[`LSIM_SEL_MSB:`LSIM_SEL_LSB];
  wire lsim_rx_fmt_t rx_fmt =
    lsim_rx_fmt_t'(rx_config_reg_q[`LSIM_FMT_MSB:`LSIM_FMT_LSB]);
  wire lsim_tx_fmt_t tx_fmt =
    lsim_tx_fmt_t'(tx_config_reg_q[`LSIM_FMT_MSB:`LSIM_FMT_LSB]);

  wire rx_sr = (rx_fmt == LSIM_RXF_SR_NRZ);
  wire rx_sliced = (rx_fmt == LSIM_RXF_DR_SLICED);
  wire tx_sr = (tx_fmt == LSIM_TXF_SR_NRZ);
  wire tx_rz = (tx_fmt == LSIM_TXF_DR_RZ);

  // ----------------------------------------
  // Pin input synchronisers
  // ----------------------------------------
  // Bit 0 recovered clock, bit 1 shared transmit pin.
  // A level is taken only when stages two and three agree.
  wire [1:0] pin_raw = {i_tx_negative_data_pin, i_recovered_clock};
  logic [1:0] pin_s1_q;
  logic [1:0] pin_s2_q;
  logic [1:0] pin_s3_q;
  logic [1:0] pin_f_q;
  wire [1:0] pin_agree = ~(pin_s2_q ^ pin_s3_q);
  wire [1:0] pin_f_d = (pin_agree & pin_s3_q) | (~pin_agree & pin_f_q);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
      pin_s3_q <= 2'h0;
      pin_f_q <= 2'h0;
    end else if (i_ce) begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_f_q <= pin_f_d;
    end
  end

  wire rclk_f = pin_f_q[0];
  wire tx_pin_f = pin_f_q[1];

  // ----------------------------------------
  // Pattern synchronisation, rx and tx
  // ----------------------------------------
  // Index 0 receive path, index 1 transmit path.
  wire [1:0] pv = {i_tx_stat.pat_valid, i_rx_stat.pat_valid};
  wire [1:0] pm = {i_tx_stat.pat_match, i_rx_stat.pat_match};
  wire [1:0] psync;
  wire [1:0] perr;

  for (genvar g = 0; g < 2; g++) begin : g_pat
    logic sync_q;
    logic [6:0] run_q;
    logic [6:0] ecnt_q;
    // Full 64-bit history keeps the window truly sliding
    logic [63:0] hist_q;
    wire miss = pv[g] & ~pm[g];
    wire [6:0] ecnt_n = ecnt_q + {6'h00, miss} - {6'h00, hist_q[63]};

    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        sync_q <= 1'b0;
        run_q <= 7'h00;
        ecnt_q <= 7'h00;
        hist_q <= 64'h0000_0000_0000_0000;
      end else if (i_ce && pv[g]) begin
        if (!sync_q) begin
          hist_q <= 64'h0000_0000_0000_0000;
          ecnt_q <= 7'h00;
          if (!pm[g]) begin
            run_q <= 7'h00;
          end else if (run_q == `LSIM_SYNC_RUN) begin
            sync_q <= 1'b1;
          end else begin
            run_q <= run_q + 7'h01;
          end
        end else if (ecnt_n > `LSIM_ERR_LIMIT) begin
          sync_q <= 1'b0;
          run_q <= 7'h00;
          ecnt_q <= 7'h00;
          hist_q <= 64'h0000_0000_0000_0000;
        end else begin
          hist_q <= {hist_q[62:0], miss};
          ecnt_q <= ecnt_n;
        end
      end
    end

    assign psync[g] = sync_q;
    assign perr[g] = sync_q & miss;
  end

  // ----------------------------------------
  // Indication sources
  // ----------------------------------------
  wire [7:0] rx_src = {
    i_rx_stat.loss,
    i_rx_stat.exz | i_rx_stat.viol,
    i_rx_stat.viol,
    i_rx_stat.exz,
    rclk_f,
    i_rx_stat.pos ^ i_rx_stat.neg,
    i_rx_stat.alarm,
    psync[0] & ~perr[0]
  };

  wire [7:0] tx_src = {
    i_tx_stat.loss,
    i_tx_stat.exz | i_tx_stat.viol,
    i_tx_stat.viol,
    i_tx_stat.exz,
    i_tx_stat.line_loss,
    i_tx_stat.over_cur,
    i_tx_stat.alarm,
    psync[1] & ~perr[1]
  };

  // Reserved selects in single-rail NRZ read as a quiet low pin
  wire tx_blocked = tx_sr && (tx_sel >= 3'h5);
  wire rx_ind_d = rx_src[rx_sel];
  wire tx_ind_d = tx_src[tx_sel] & ~tx_blocked;

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  // Every pin comes from a flop, so a select write never glitches it.
  wire rx_neg_d = rx_sr ? rx_ind_d : i_rx_stat.neg;
  wire rclk_pin_d = rx_sliced ? rx_ind_d : rclk_f;
  wire tx_oe_d = tx_sr | tx_rz;
  logic rx_ind_q;
  logic tx_ind_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rx_negative_data_pin <= 1'b0;
      o_recovered_clock_pin <= 1'b0;
      o_tx_negative_data_pin <= 1'b0;
      o_tx_negative_data_oe <= 1'b0;
      rx_ind_q <= 1'b0;
      tx_ind_q <= 1'b0;
    end else if (i_ce) begin
      o_rx_negative_data_pin <= rx_neg_d;
      o_recovered_clock_pin <= rclk_pin_d;
      o_tx_negative_data_pin <= tx_ind_d;
      o_tx_negative_data_oe <= tx_oe_d;
      rx_ind_q <= rx_ind_d;
      tx_ind_q <= tx_ind_d;
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // Answer is ready in the first access cycle, no wait states.
  wire ap_setup = i_psel & ~i_penable;
  wire ap_done = i_psel & i_penable & o_pready;
  wire ap_wr = ap_done & i_pwrite;
  wire hit_rx = (i_paddr == `LSIM_RX_CFG_OFS);
  wire hit_tx = (i_paddr == `LSIM_TX_CFG_OFS);
  wire hit_st = (i_paddr == `LSIM_STAT_OFS);
  wire hit_any = hit_rx | hit_tx | hit_st;

  wire [15:0] stat_word = {
    4'h0,
    tx_pin_f,
    rclk_f,
    tx_ind_q,
    rx_ind_q,
    i_tx_stat.loss,
    i_tx_stat.line_loss,
    i_tx_stat.over_cur,
    i_tx_stat.alarm,
    i_rx_stat.loss,
    i_rx_stat.alarm,
    psync[1],
    psync[0]
  };

  wire [31:0] rd_d =
    hit_rx ? {24'h00_0000, rx_config_reg_q} :
    hit_tx ? {24'h00_0000, tx_config_reg_q} :
    hit_st ? {16'h0000, stat_word} : 32'h0000_0000;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (i_ce) begin
      o_pready <= ap_setup;
      o_pslverr <= ap_setup & ~hit_any;
      if (ap_setup) begin
        o_prdata <= i_pwrite ? 32'h0000_0000 : rd_d;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_config_reg_q <= `LSIM_RX_CFG_RST;
      tx_config_reg_q <= `LSIM_TX_CFG_RST;
    end else if (i_ce && ap_wr) begin
      if (hit_rx) begin
        rx_config_reg_q <= i_pwdata[7:0];
      end
      if (hit_tx) begin
        tx_config_reg_q <= i_pwdata[7:0];
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_rx_sync_high;
    i_ce && rx_sr && rx_sel == 3'h0 && psync[0] && !perr[0]
      |=> o_rx_negative_data_pin;
  endproperty
  a_rx_sync_high: assert property (p_rx_sync_high)
    else $error("rx pin not high while pattern synchronized");

  property p_rx_err_low;
    i_ce && rx_sr && rx_sel == 3'h0 && (perr[0] || !psync[0])
      |=> !o_rx_negative_data_pin;
  endproperty
  a_rx_err_low: assert property (p_rx_err_low)
    else $error("rx pin not low on pattern error or loss of sync");

  property p_rx_alarm;
    i_ce && rx_sr && rx_sel == 3'h1
      |=> o_rx_negative_data_pin == $past(i_rx_stat.alarm);
  endproperty
  a_rx_alarm: assert property (p_rx_alarm)
    else $error("rx pin does not follow line alarm");

  property p_rx_xor;
    i_ce && rx_sliced && rx_sel == 3'h2
      |=> o_recovered_clock_pin
        == ($past(i_rx_stat.pos) ^ $past(i_rx_stat.neg));
  endproperty
  a_rx_xor: assert property (p_rx_xor)
    else $error("clock pin does not show rail xor");

  property p_rx_either;
    i_ce && rx_sr && rx_sel == 3'h6
      |=> o_rx_negative_data_pin
        == ($past(i_rx_stat.exz) | $past(i_rx_stat.viol));
  endproperty
  a_rx_either: assert property (p_rx_either)
    else $error("rx pin misses zeroes or violation pulse");

  property p_rx_loss;
    i_ce && rx_sr && rx_sel == 3'h7
      |=> o_rx_negative_data_pin == $past(i_rx_stat.loss);
  endproperty
  a_rx_loss: assert property (p_rx_loss)
    else $error("rx pin does not follow line loss");

  property p_tx_oe;
    i_ce |=> o_tx_negative_data_oe == $past(tx_sr | tx_rz);
  endproperty
  a_tx_oe: assert property (p_tx_oe)
    else $error("tx pin enable does not match format");

  property p_tx_reserved;
    i_ce && tx_sr && tx_sel >= 3'h5 |=> !o_tx_negative_data_pin;
  endproperty
  a_tx_reserved: assert property (p_tx_reserved)
    else $error("tx pin active on reserved select");

  property p_tx_oc;
    i_ce && tx_sel == 3'h2
      |=> o_tx_negative_data_pin == $past(i_tx_stat.over_cur);
  endproperty
  a_tx_oc: assert property (p_tx_oc)
    else $error("tx pin does not follow over current");

  property p_rx_zeroes;
    i_ce && rx_sr && rx_sel == 3'h4
      |=> o_rx_negative_data_pin == $past(i_rx_stat.exz);
  endproperty
  a_rx_zeroes: assert property (p_rx_zeroes)
    else $error("rx pin misses excess zeroes pulse");

  property p_rx_viol;
    i_ce && rx_sr && rx_sel == 3'h5
      |=> o_rx_negative_data_pin == $past(i_rx_stat.viol);
  endproperty
  a_rx_viol: assert property (p_rx_viol)
    else $error("rx pin misses violation pulse");

  // A pattern error in sync followed by a clean bit gives one low cycle, then high
  sequence s_rx_err;
    i_ce && rx_sr && rx_sel == 3'h0 && perr[0];
  endsequence
  sequence s_rx_clean;
    i_ce && rx_sr && rx_sel == 3'h0 && psync[0] && !perr[0];
  endsequence

  property p_rx_err_pulse;
    s_rx_err ##1 s_rx_clean
      |-> !o_rx_negative_data_pin ##1 o_rx_negative_data_pin;
  endproperty
  a_rx_err_pulse: assert property (p_rx_err_pulse)
    else $error("rx pattern error pulse is not one cycle wide");

  property p_rx_sync_rise;
    $rose(psync[0]) |-> $past(i_ce && pv[0] && pm[0]);
  endproperty
  a_rx_sync_rise: assert property (p_rx_sync_rise)
    else $error("rx sync rose without a matching bit");

  property p_rx_sync_fall;
    $fell(psync[0]) |-> $past(perr[0]);
  endproperty
  a_rx_sync_fall: assert property (p_rx_sync_fall)
    else $error("rx sync fell without a pattern error");

endmodule

// >>> tb/lsim_framer_model.sv
// System-side framer model on the shared transmit negative data pin.
// Assumes the indication block drives the pin only while its enable is high.
`timescale 1ns/1ps

module lsim_framer_model (
  // Clock
  input wire logic i_clk,
  // Shared pin, block side
  input wire logic i_dut_pin,
  input wire logic i_dut_oe,
  // Resolved pin level
  output logic o_wire
);
  logic data_q = 1'b0;

  // Toggles each cycle so a stale level is never mistaken for a drive
  always_ff @(posedge i_clk) begin
    data_q <= ~data_q;
  end

  assign o_wire = i_dut_oe ? i_dut_pin : data_q;
endmodule

// >>> tb/testbench.sv
// Self-checking bench: APB configuration, then indication pin sequences.
// Assumes one 10 MHz clock and registered pins one cycle behind inputs.
`timescale 1ns/1ps
`include "lsim_map.svh"
`define CHK(g, e) check(g, e)

module testbench
  import lsim_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic o_pready, o_pslverr, o_tx_negative_data_pin, o_tx_negative_data_oe;
  logic o_rx_negative_data_pin, o_recovered_clock_pin, tx_wire;
  logic [31:0] o_prdata, q;
  lsim_rx_stat_t rx_stat = '0;
  lsim_tx_stat_t tx_stat = '0;
  logic rclk = 1'b0;
  logic e, xr, xt;
  logic ce = 1'b1;
  int errors = 0;
  int total_checks = 0;
  int f, s, v;

  always #50 i_clk = ~i_clk;

  lsim_top u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(o_pready),
    .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_rx_stat(rx_stat),
    .i_tx_stat(tx_stat), .i_recovered_clock(rclk),
    .i_tx_negative_data_pin(tx_wire),
    .o_tx_negative_data_pin(o_tx_negative_data_pin),
    .o_tx_negative_data_oe(o_tx_negative_data_oe),
    .o_rx_negative_data_pin(o_rx_negative_data_pin),
    .o_recovered_clock_pin(o_recovered_clock_pin));

  lsim_framer_model u_framer (.i_clk(i_clk),
    .i_dut_pin(o_tx_negative_data_pin), .i_dut_oe(o_tx_negative_data_oe),
    .o_wire(tx_wire));

  task check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task end_sim();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------
  // APB master
  // ----------------------------------------
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge i_clk);
    end while (o_pready !== 1'b1);
    q = o_prdata;
    e = o_pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task cfg(input logic [2:0] rs, input logic [1:0] rf,
           input logic [2:0] ts, input logic [1:0] tf);
    apb(1'b1, `LSIM_RX_CFG_OFS, {24'h00_0000, rs, 3'h0, rf});
    apb(1'b1, `LSIM_TX_CFG_OFS, {24'h00_0000, ts, 3'h0, tf});
    apb(1'b0, `LSIM_TX_CFG_OFS, 32'h0000_0000);
    `CHK(q, {24'h00_0000, ts, 3'h0, tf});
    apb(1'b0, `LSIM_RX_CFG_OFS, 32'h0000_0000);
    `CHK(q, {24'h00_0000, rs, 3'h0, rf});
  endtask

  // One sample per cycle; returns where the pins show it
  task step(input logic [7:0] x);
    rx_stat <= lsim_rx_stat_t'(x);
    tx_stat <= lsim_tx_stat_t'(x);
    @(posedge i_clk);
    #1;
  endtask

  task chk2(input logic x);
    `CHK(o_rx_negative_data_pin, x);
    `CHK(o_tx_negative_data_pin, x);
  endtask

  function automatic logic exp_ind(input logic tx, input logic [2:0] sl,
                                   input logic [7:0] x, input logic sr);
    if (!tx) begin
      case (sl)
        3'd1: return x[5];
        3'd2: return x[1] ^ x[0];
        3'd4: return x[3];
        3'd5: return x[2];
        3'd6: return x[3] | x[2];
        3'd7: return x[4];
        default: return 1'b0;
      endcase
    end
    case (sl)
      3'd1: return x[5];
      3'd2: return x[4];
      3'd3: return x[3];
      3'd4: return x[2];
      3'd5: return x[1] & !sr;
      3'd6: return (x[2] | x[1]) & !sr;
      3'd7: return x[0] & !sr;
      default: return 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    #(10000 * 100);
    errors++;
    end_sim();
  end

  initial begin
    repeat (6) @(posedge i_clk);
    `CHK(o_tx_negative_data_oe, 1'b0);
    i_rst <= 1'b0;
    apb(1'b0, 8'h0C, 32'h0000_0000);
    `CHK(e, 1'b1);
    `CHK(q, 32'h0000_0000);
    $display("test reset and map done");
    // Pattern detector never valid here, so select 000 stays low
    for (f = 0; f < 2; f++) begin
      for (s = 0; s < 8; s++) begin
        cfg(s[2:0], 2'(f * 2), s[2:0], 2'(f * 2));
        for (v = 0; v < 128; v++) begin
          step(v[7:0]);
          xr = exp_ind(1'b0, s[2:0], v[7:0], 1'b0);
          xt = exp_ind(1'b1, s[2:0], v[7:0], f == 0);
          if (f == 0) begin
            `CHK(o_rx_negative_data_pin, xr);
            `CHK(o_recovered_clock_pin, 1'b0);
          end else begin
            `CHK(o_recovered_clock_pin, xr);
            `CHK(o_rx_negative_data_pin, v[0]);
          end
          `CHK(o_tx_negative_data_pin, xt);
          `CHK(o_tx_negative_data_oe, 1'b1);
        end
      end
    end
    // Dual NRZ both ways: rx loss set, neg low, no pin carries the indication
    cfg(3'd7, 2'd1, 3'd7, 2'd1);
    step(8'h10);
    `CHK(o_tx_negative_data_oe, 1'b0);
    `CHK(o_rx_negative_data_pin, 1'b0);
    `CHK(o_recovered_clock_pin, 1'b0);
    cfg(3'd0, 2'd0, 3'd0, 2'd3);
    step(8'h00);
    `CHK(o_tx_negative_data_oe, 1'b0);
    $display("test select table done");
    cfg(3'd3, 2'd0, 3'd0, 2'd0);
    rclk <= 1'b1;
    repeat (8) step(8'h00);
    `CHK(o_rx_negative_data_pin, 1'b1);
    rclk <= 1'b0;
    repeat (8) step(8'h00);
    `CHK(o_rx_negative_data_pin, 1'b0);
    $display("test recovered clock done");
    cfg(3'd0, 2'd0, 3'd0, 2'd0);
    // Sync must follow the 65th match, not a cycle earlier or later
    repeat (65) step(8'hC0);
    chk2(1'b0);
    step(8'h00);
    chk2(1'b1);
    // Let the shared pin settle through the input filter first
    repeat (4) step(8'h00);
    apb(1'b0, `LSIM_STAT_OFS, 32'h0000_0000);
    `CHK(q, 32'h0000_0B03);
    step(8'h80);
    chk2(1'b0);
    step(8'h00);
    chk2(1'b1);
    repeat (5) step(8'h80);
    step(8'h00);
    chk2(1'b1);
    step(8'h80);
    step(8'h00);
    step(8'h00);
    chk2(1'b0);
    $display("test pattern sync done");
    cfg(3'd1, 2'd0, 3'd1, 2'd0);
    step(8'h20);
    chk2(1'b1);
    // Clock enable low must freeze the pins
    ce <= 1'b0;
    step(8'h00);
    chk2(1'b1);
    ce <= 1'b1;
    step(8'h00);
    chk2(1'b0);
    $display("test clock enable done");
    end_sim();
  end
endmodule
